// ===== logic/dpl_pull_in_limit.v
// pull-in limit register bank with symmetric clamp of both tracking loop offsets
`timescale 1ns/1ps
`include "dpl_regs.vh"
module dpl_pull_in_limit #(
    parameter OFS_WIDTH = 16
) (
    input  wire                        sys_clk,
    input  wire                        reset,
    input  wire [6:0]                  reg_addr,
    input  wire                        reg_write,
    input  wire [7:0]                  reg_wdata,
    output reg  [7:0]                  reg_rdata,
    input  wire signed [OFS_WIDTH-1:0] first_loop_raw_offset,
    input  wire signed [OFS_WIDTH-1:0] second_loop_raw_offset,
    input  wire signed [OFS_WIDTH-1:0] osc_calibration,
    output reg  [9:0]                  loop_pull_in_limit,
    output reg  signed [OFS_WIDTH-1:0] first_tracking_loop_offset,
    output reg  signed [OFS_WIDTH-1:0] second_tracking_loop_offset
);

    localparam LOOP_COUNT  = 2;
    localparam LIMIT_WIDTH = `DPL_LIMIT_WIDTH;
    localparam WIDE_WIDTH  = OFS_WIDTH + 2;

    // stored register bytes and their next values
    reg  [7:0]                   limit_low;
    reg  [1:0]                   limit_high;
    reg  [7:0]                   next_limit_low;
    reg  [1:0]                   next_limit_high;

    // read path
    reg  [7:0]                   next_rdata;

    // assembled limit and the clamp bounds derived from it
    wire [LIMIT_WIDTH-1:0]       limit_value;
    wire signed [WIDE_WIDTH-1:0] lim_pos;
    wire signed [WIDE_WIDTH-1:0] lim_neg;
    wire signed [WIDE_WIDTH-1:0] cal_wide;

    // per-loop offsets before and after the clamp
    wire signed [OFS_WIDTH-1:0]  raw_offset [0:LOOP_COUNT-1];
    wire signed [OFS_WIDTH-1:0]  next_offset [0:LOOP_COUNT-1];

    // ------------------------------------------------------------
    // address decoding, shared by the write and the read path
    // ------------------------------------------------------------

    function addr_is_low;
        input [6:0] addr;
        begin
            addr_is_low = (addr == `DPL_ADDR_LIMIT_LOW);
        end
    endfunction

    function addr_is_high;
        input [6:0] addr;
        begin
            addr_is_high = (addr == `DPL_ADDR_LIMIT_HIGH);
        end
    endfunction

    // ------------------------------------------------------------
    // arithmetic helpers
    // ------------------------------------------------------------

    // two guard bits so raw minus calibration never wraps
    function signed [WIDE_WIDTH-1:0] widen;
        input signed [OFS_WIDTH-1:0] value;
        begin
            widen = {{2{value[OFS_WIDTH-1]}}, value};
        end
    endfunction

    function signed [OFS_WIDTH-1:0] clamp;
        input signed [WIDE_WIDTH-1:0] rel;
        input signed [WIDE_WIDTH-1:0] hi;
        input signed [WIDE_WIDTH-1:0] lo;
        reg   signed [WIDE_WIDTH-1:0] kept;
        begin
            kept = rel;

            if (rel > hi) begin
                kept = hi;
            end else if (rel < lo) begin
                kept = lo;
            end

            // hi is under 1024, so lo..hi always fits the output width
            clamp = kept[OFS_WIDTH-1:0];
        end
    endfunction

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------

    always @* begin
        next_limit_low  = limit_low;
        next_limit_high = limit_high;

        if (reg_write) begin
            if (addr_is_low(reg_addr)) begin
                next_limit_low = reg_wdata;
            end else if (addr_is_high(reg_addr)) begin
                next_limit_high = reg_wdata[`DPL_HIGH_FIELD_MSB:0];
            end
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            limit_low  <= `DPL_LIMIT_LOW_RESET;
            limit_high <= `DPL_LIMIT_HIGH_RESET;
        end else begin
            limit_low  <= next_limit_low;
            limit_high <= next_limit_high;
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------

    // unmapped addresses read zero rather than aliasing a register
    always @* begin
        next_rdata = 8'h00;

        if (addr_is_low(reg_addr)) begin
            next_rdata = limit_low;
        end else if (addr_is_high(reg_addr)) begin
            next_rdata = {6'h00, limit_high};
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // limit assembly
    // ------------------------------------------------------------

    assign limit_value = {limit_high, limit_low};

    always @(posedge sys_clk) begin
        if (reset) begin
            loop_pull_in_limit <= 10'h000;
        end else begin
            loop_pull_in_limit <= limit_value;
        end
    end

    // bounds follow the published limit, so the clamp never runs ahead of it
    assign lim_pos  = $signed({{(WIDE_WIDTH-LIMIT_WIDTH){1'b0}}, loop_pull_in_limit});
    assign lim_neg  = -lim_pos;

    // ------------------------------------------------------------
    // offset measurement and clamp, one copy per tracking loop
    // ------------------------------------------------------------

    // a zero calibration leaves the raw crystal-relative offset unchanged
    assign cal_wide = widen(osc_calibration);

    assign raw_offset[0] = first_loop_raw_offset;
    assign raw_offset[1] = second_loop_raw_offset;

    genvar loop_idx;

    generate
        for (loop_idx = 0; loop_idx < LOOP_COUNT; loop_idx = loop_idx + 1) begin : g_loop
            wire signed [WIDE_WIDTH-1:0] rel_offset;

            assign rel_offset = widen(raw_offset[loop_idx]) - cal_wide;

            assign next_offset[loop_idx] = clamp(rel_offset, lim_pos, lim_neg);
        end
    endgenerate

    // ------------------------------------------------------------
    // loop offset outputs
    // ------------------------------------------------------------

    always @(posedge sys_clk) begin
        if (reset) begin
            first_tracking_loop_offset <= {OFS_WIDTH{1'b0}};
        end else begin
            first_tracking_loop_offset <= next_offset[0];
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            second_tracking_loop_offset <= {OFS_WIDTH{1'b0}};
        end else begin
            second_tracking_loop_offset <= next_offset[1];
        end
    end

    // ------------------------------------------------------------
    // timing summary
    // ------------------------------------------------------------
    //
    // write edge       : byte stored
    // one edge later   : limit published on loop_pull_in_limit
    // two edges later  : loop offsets clamped with the new limit
    //
    // read data follows the address by one edge
    //
    // the clamp is combinational between the loop inputs and the
    // output flops, so a loop input change shows after one edge
    //

endmodule // dpl_pull_in_limit

// ===== include/dpl_regs.vh
// register offsets, field positions and reset values for the pull-in limit bank
// Notes on behaviour
// - each of the two tracking loops follows source offset only up to the limit.
// - offset is judged against the device's own crystal oscillator.
// - a programmed oscillator calibration is folded into the offset automatically.
// - limit is 10-bit unsigned; high register bits 1:0 give bits 9:8.
// - the same limit bounds positive and negative offsets alike.
`ifndef DPL_REGS_VH
`define DPL_REGS_VH
`define DPL_ADDR_LIMIT_LOW  7'h41
`define DPL_ADDR_LIMIT_HIGH 7'h42
`define DPL_LIMIT_LOW_RESET  8'h00
`define DPL_LIMIT_HIGH_RESET 2'h0
`define DPL_LIMIT_WIDTH 10
`define DPL_HIGH_FIELD_MSB 1
`endif

// ===== verification/dpl_pull_in_limit_checker.sv
// assertions for the pull-in limit bank
`timescale 1ns/1ps
module dpl_chk #(parameter OFS_WIDTH = 16) (input wire sys_clk, reset, reg_write, input wire [6:0] reg_addr,
input wire [7:0] reg_wdata, reg_rdata, input wire [9:0] loop_pull_in_limit,
input wire signed [OFS_WIDTH-1:0] first_loop_raw_offset, osc_calibration, first_tracking_loop_offset);
wire signed [OFS_WIDTH:0] lim = {1'b0, loop_pull_in_limit}, o = first_tracking_loop_offset,
    dif = first_loop_raw_offset - osc_calibration;
default clocking @(posedge sys_clk); endclocking
default disable iff (reset);
sequence s_wr_lo; reg_write && reg_addr == 7'h41; endsequence
sequence s_wr_hi; reg_write && reg_addr == 7'h42; endsequence
property p_lo; s_wr_lo |=> ##1 loop_pull_in_limit[7:0] == $past(reg_wdata, 2); endproperty
a_lo: assert property (p_lo) else $error("low byte lost");
property p_hb; s_wr_hi |=> ##1 loop_pull_in_limit[9:8] == $past(reg_wdata[1:0], 2); endproperty
a_hb: assert property (p_hb) else $error("high bits lost");
property p_rd; reg_addr == 7'h42 |=> reg_rdata[7:2] == 6'h00; endproperty
a_rd: assert property (p_rd) else $error("spare bits set");
property p_hi; dif > lim |=> o == $past(lim); endproperty
a_hi: assert property (p_hi) else $error("no upper clamp");
property p_neg; dif < -lim |=> o == -$past(lim); endproperty
a_neg: assert property (p_neg) else $error("no lower clamp");
property p_in; dif <= lim && dif >= -lim |=> o == $past(dif); endproperty
a_in: assert property (p_in) else $error("offset altered");
endmodule // dpl_chk
bind dpl_pull_in_limit dpl_chk #(.OFS_WIDTH(OFS_WIDTH)) dpl_chk_i (.*);

// ===== verification/test_dpl_pull_in_limit.sv
// bench for the pull-in limit bank
`timescale 1ns/1ps
module test_dpl_pull_in_limit;
reg sys_clk = 0, reset = 1, reg_write = 0;
reg [6:0] reg_addr = 7'h00;
reg [7:0] reg_wdata = 8'h00;
reg signed [15:0] first_loop_raw_offset = 0, second_loop_raw_offset = 0, osc_calibration = 0;
wire [7:0] reg_rdata;
wire [9:0] loop_pull_in_limit;
wire signed [15:0] first_tracking_loop_offset, second_tracking_loop_offset;
integer err_count = 0, compares = 0, cyc = 0;
dpl_pull_in_limit dpl_pull_in_limit_i (.*);
always #25 sys_clk = ~sys_clk;
task chk(input [15:0] g, e); begin compares++;
    if (g !== e) begin err_count++; $display("[ERR] %0t got %h want %h", $time, g, e); end end endtask
task tally_and_finish; begin $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish; end endtask
always @(posedge sys_clk) if (++cyc > 900) begin err_count++; tally_and_finish; end
task wr(input [6:0] a, input [7:0] d); begin @(negedge sys_clk) {reg_addr, reg_wdata, reg_write} = {a, d, 1'b1};
    @(negedge sys_clk) reg_write = 0; end endtask
task rd(input [6:0] a, input [7:0] e); begin @(negedge sys_clk) reg_addr = a; @(negedge sys_clk) chk(reg_rdata, e); end endtask
task t_regs; begin rd(7'h41, 8'h00); rd(7'h42, 8'h00);
    wr(7'h42, 8'hFF); wr(7'h41, 8'h5A); wr(7'h43, 8'hFF); rd(7'h42, 8'h03);
    rd(7'h41, 8'h5A); rd(7'h40, 8'h00); chk(loop_pull_in_limit, 16'h035A); end endtask
task ofs(input [15:0] f, s, c, ef, es); begin @(negedge sys_clk)
    {first_loop_raw_offset, second_loop_raw_offset, osc_calibration} = {f, s, c};
    @(negedge sys_clk) chk(first_tracking_loop_offset, ef); chk(second_tracking_loop_offset, es); end endtask
task t_clamp; begin ofs(16'h07D0, 16'hF830, 16'h0000, 16'h035A, 16'hFCA6);
    ofs(16'h01F4, 16'hFE0C, 16'h0064, 16'h0190, 16'hFDA8);
    ofs(16'h035A, 16'hFCA5, 16'h0000, 16'h035A, 16'hFCA6);
    wr(7'h42, 8'h00); wr(7'h41, 8'h00); ofs(16'h0005, 16'hFFFB, 16'h0000, 16'h0000, 16'h0000); end endtask
initial begin repeat (16) @(negedge sys_clk); reset = 0; t_regs; t_clamp; tally_and_finish; end
endmodule // test_dpl_pull_in_limit
